// ### ccdr_pkg.sv
// Package for the CCD frame readout sequencer: geometry, timing and types
package ccdr_pkg;
    // Array geometry
    localparam int COLS_TOTAL = 3991;
    localparam int ROWS_TOTAL = 2679;
    localparam int COLS_EFFECTIVE = 3916;
    localparam int ROWS_EFFECTIVE = 2624;
    localparam int COLS_ACTIVE = 3876;
    localparam int ROWS_ACTIVE = 2584;
    localparam int DARK_PIXELS_PER_END = 24;
    localparam int DARK_LINES_PER_END = 27;
    localparam int DUMMY_LEADING = 3;
    localparam int BUFFER_PIXELS = 20;
    localparam int SHIFTS_PER_ROW = COLS_TOTAL + DUMMY_LEADING;
    localparam int COL_W = 12;
    localparam int ROW_W = 12;
    localparam int SAMPLE_W = 16;
    // Timing
    localparam int CLOCK_HZ = 25000000;
    localparam int INTEGRATION_MS = 250;
    localparam int INTEGRATION_CYCLES_DEF = INTEGRATION_MS * (CLOCK_HZ / 1000);
    localparam int VPHASE_NS = 2000;
    localparam int VPHASE_CYCLES = (VPHASE_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
    localparam int HHALF_CYCLES = 1;
    localparam int RESET_GATE_CYCLES = 1;
    // Cycles for a new sample to pass the two input flops
    localparam int SAMPLE_SETTLE_CYCLES = 2;

    typedef enum logic [2:0] {
        CCDR_REGION_DUMMY,
        CCDR_REGION_DARK,
        CCDR_REGION_BUFFER,
        CCDR_REGION_ACTIVE,
        CCDR_REGION_DARK_LINE
    } ccdr_region_t;

    typedef struct packed {
        logic vertical_phase_one;
        logic vertical_phase_two;
        logic horizontal_phase_one;
        logic horizontal_phase_two;
        logic horizontal_last_gate;
        logic reset_gate_clock;
    } ccdr_clocks_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] sample;
        logic [COL_W-1:0] column;
        logic [ROW_W-1:0] row;
        ccdr_region_t region;
        logic scavenging;
    } ccdr_pixel_t;
endpackage

// ### ccdr_sequencer.sv
// Timing generator that clocks the CCD and tags each sampled pixel
//
// Functional notes
// - Scavenging pixels flagged, not excluded from dark reference regions
// - Row transfer first, then pixel shift out
// - Row transfer on phase two fall, H1 high
// - Horizontal phases toggle, always complementary
// - Last gate driven like horizontal phase one
// - Vertical phases low during integration
// - Reset gate pulsed after each sample
// - Integrate then readout, 250 ms default
`timescale 1ns/10ps
`default_nettype none
module ccdr_sequencer
    import ccdr_pkg::*;
#(
    parameter int INTEGRATION_CYCLES = INTEGRATION_CYCLES_DEF
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [SAMPLE_W-1:0] adc_sample,
    output logic busy,
    output ccdr_clocks_t ccd_clocks,
    output logic out_valid,
    input wire logic out_ready,
    output ccdr_pixel_t out_pixel
);

    // ***************************************************
    // Region decoding
    // ***************************************************
    // horizontal region
    function automatic ccdr_region_t col_region(input logic [COL_W-1:0] c);
        int p;
        p = int'(c);
        if (p < DUMMY_LEADING)
            col_region = CCDR_REGION_DUMMY;
        else if (p < DUMMY_LEADING + DARK_PIXELS_PER_END
                 || p >= SHIFTS_PER_ROW - DARK_PIXELS_PER_END)
            col_region = CCDR_REGION_DARK;
        else if (p < DUMMY_LEADING + DARK_PIXELS_PER_END + BUFFER_PIXELS
                 || p >= SHIFTS_PER_ROW - DARK_PIXELS_PER_END - BUFFER_PIXELS)
            col_region = CCDR_REGION_BUFFER;
        else
            col_region = CCDR_REGION_ACTIVE;
    endfunction

    function automatic ccdr_region_t pix_region(input logic [COL_W-1:0] c, input logic [ROW_W-1:0] r);
        int q;
        q = int'(r);
        // Dummy shifts belong to no column, so no line can make them dark reference
        if (col_region(c) == CCDR_REGION_DUMMY)
            pix_region = CCDR_REGION_DUMMY;
        else if (q < DARK_LINES_PER_END || q >= ROWS_TOTAL - DARK_LINES_PER_END)
            pix_region = CCDR_REGION_DARK_LINE;
        else if ((q < DARK_LINES_PER_END + (ROWS_EFFECTIVE - ROWS_ACTIVE) / 2
                  || q >= ROWS_TOTAL - DARK_LINES_PER_END - (ROWS_EFFECTIVE - ROWS_ACTIVE) / 2)
                 && col_region(c) == CCDR_REGION_ACTIVE)
            pix_region = CCDR_REGION_BUFFER;
        else
            pix_region = col_region(c);
    endfunction

    // dark pixels next to lit or test pixels
    function automatic logic is_scavenging(input logic [COL_W-1:0] c, input logic [ROW_W-1:0] r);
        int p;
        int q;
        p = int'(c);
        q = int'(r);
        is_scavenging = (p == DUMMY_LEADING + DARK_PIXELS_PER_END - 1)
                     || (p == SHIFTS_PER_ROW - DARK_PIXELS_PER_END)
                     || (p == DUMMY_LEADING)
                     || (q == DARK_LINES_PER_END - 1)
                     || (q == ROWS_TOTAL - DARK_LINES_PER_END);
    endfunction

    // ***************************************************
    // Sequencer
    // ***************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INTEGRATE,
        ST_V1_HIGH,
        ST_V2_HIGH,
        ST_V2_FALL,
        ST_H_SHIFT,
        ST_RESET_GATE
    } ccdr_state_t;

    ccdr_state_t state_reg, state_next;
    logic [31:0] timer_reg, timer_next;
    logic [COL_W-1:0] col_reg, col_next;
    logic [ROW_W-1:0] row_reg, row_next;
    logic h1_reg, h1_next;
    logic v1_reg, v1_next;
    logic v2_reg, v2_next;
    logic rg_reg, rg_next;
    logic [SAMPLE_W-1:0] adc_meta_reg, adc_sync_reg;
    logic push;
    logic buf_ready;
    ccdr_pixel_t push_pixel;

    always_comb
    begin
        state_next = state_reg;
        timer_next = timer_reg;
        col_next = col_reg;
        row_next = row_reg;
        h1_next = h1_reg;
        v1_next = v1_reg;
        v2_next = v2_reg;
        rg_next = 1'b0;
        push = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                h1_next = 1'b1;
                if (start)
                begin
                    state_next = ST_INTEGRATE;
                    timer_next = 32'h0;
                end
            end
            ST_INTEGRATE:
            begin
                v1_next = 1'b0;
                v2_next = 1'b0;
                timer_next = timer_reg + 32'h1;
                if (timer_reg >= 32'(INTEGRATION_CYCLES - 1))
                begin
                    state_next = ST_V1_HIGH;
                    timer_next = 32'h0;
                    row_next = '0;
                end
            end
            ST_V1_HIGH:
            begin
                v1_next = 1'b1;
                h1_next = 1'b1;
                timer_next = timer_reg + 32'h1;
                if (timer_reg >= 32'(VPHASE_CYCLES - 1))
                begin
                    state_next = ST_V2_HIGH;
                    timer_next = 32'h0;
                end
            end
            ST_V2_HIGH:
            begin
                v1_next = 1'b0;
                v2_next = 1'b1;
                timer_next = timer_reg + 32'h1;
                if (timer_reg >= 32'(VPHASE_CYCLES - 1))
                begin
                    state_next = ST_V2_FALL;
                    timer_next = 32'h0;
                end
            end
            // phase two falls with H1 held high
            ST_V2_FALL:
            begin
                v2_next = 1'b0;
                h1_next = 1'b1;
                timer_next = timer_reg + 32'h1;
                if (timer_reg >= 32'(VPHASE_CYCLES - 1))
                begin
                    state_next = ST_H_SHIFT;
                    timer_next = 32'h0;
                    col_next = '0;
                end
            end
            ST_H_SHIFT:
            begin
                if (h1_reg)
                begin
                    h1_next = 1'b0;
                    timer_next = 32'h0;
                end
                // Wait until the new packet has crossed the input flops
                else if (timer_reg < 32'(SAMPLE_SETTLE_CYCLES))
                    timer_next = timer_reg + 32'h1;
                else if (buf_ready)
                begin
                    push = 1'b1;
                    state_next = ST_RESET_GATE;
                end
            end
            ST_RESET_GATE:
            begin
                rg_next = 1'b1;
                h1_next = 1'b1;
                state_next = ST_H_SHIFT;
                if (int'(col_reg) == SHIFTS_PER_ROW - 1)
                begin
                    if (int'(row_reg) == ROWS_TOTAL - 1)
                        state_next = ST_IDLE;
                    else
                    begin
                        row_next = row_reg + 1'b1;
                        state_next = ST_V1_HIGH;
                    end
                end
                else
                    col_next = col_reg + 1'b1;
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            timer_reg <= 32'h0;
            col_reg <= '0;
            row_reg <= '0;
            h1_reg <= 1'b1;
            v1_reg <= 1'b0;
            v2_reg <= 1'b0;
            rg_reg <= 1'b0;
            adc_meta_reg <= '0;
            adc_sync_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            col_reg <= col_next;
            row_reg <= row_next;
            h1_reg <= h1_next;
            v1_reg <= v1_next;
            v2_reg <= v2_next;
            rg_reg <= rg_next;
            adc_meta_reg <= adc_sample;
            adc_sync_reg <= adc_meta_reg;
        end
    end

    always_comb
    begin
        ccd_clocks.vertical_phase_one = v1_reg;
        ccd_clocks.vertical_phase_two = v2_reg;
        ccd_clocks.horizontal_phase_one = h1_reg;
        ccd_clocks.horizontal_phase_two = ~h1_reg;
        ccd_clocks.horizontal_last_gate = h1_reg;
        ccd_clocks.reset_gate_clock = rg_reg;
        push_pixel.sample = adc_sync_reg;
        push_pixel.column = col_reg;
        push_pixel.row = row_reg;
        push_pixel.region = pix_region(col_reg, row_reg);
        push_pixel.scavenging = is_scavenging(col_reg, row_reg);
    end
    assign busy = (state_reg != ST_IDLE);

    // ***************************************************
    // Two-entry output buffer
    // ***************************************************
    ccdr_pixel_t mem [2];
    logic wr_reg, wr_next, rd_reg, rd_next;
    logic [1:0] cnt_reg, cnt_next;
    assign buf_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_pixel = mem[rd_reg];

    always_comb
    begin
        wr_next = wr_reg ^ push;
        rd_next = rd_reg ^ (out_valid & out_ready);
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, out_valid & out_ready};
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            cnt_reg <= 2'h0;
            mem[0] <= '0;
            mem[1] <= '0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
            if (push)
                mem[wr_reg] <= push_pixel;
        end
    end

    // ***************************************************
    // Checks
    // ***************************************************
    a_h_complement: assert property (@(posedge clock) disable iff (rst)
        ccd_clocks.horizontal_phase_two == ~ccd_clocks.horizontal_phase_one)
        else $error("horizontal phases not complementary");
    a_last_gate: assert property (@(posedge clock) disable iff (rst)
        ccd_clocks.horizontal_last_gate == ccd_clocks.horizontal_phase_one)
        else $error("last gate differs from phase one");
    a_v2_fall_h1: assert property (@(posedge clock) disable iff (rst)
        $fell(ccd_clocks.vertical_phase_two) |-> ccd_clocks.horizontal_phase_one)
        else $error("phase two fell with H1 low");
    a_integrate_low: assert property (@(posedge clock) disable iff (rst)
        state_reg == ST_INTEGRATE |=> !v1_reg && !v2_reg)
        else $error("vertical clock active in integration");
    sequence s_gate_pulse;
        ##2 rg_reg ##1 !rg_reg;
    endsequence
    a_reset_after: assert property (@(posedge clock) disable iff (rst)
        push |-> s_gate_pulse)
        else $error("reset gate not pulsed after sample");
    a_one_packet: assert property (@(posedge clock) disable iff (rst)
        $fell(h1_reg) && state_reg == ST_H_SHIFT |-> ##[1:1000] push)
        else $error("no sample after phase one fall");
    a_dummy_tag: assert property (@(posedge clock) disable iff (rst)
        push && int'(col_reg) < DUMMY_LEADING |-> push_pixel.region == CCDR_REGION_DUMMY)
        else $error("dummy shift mis-tagged");
    a_dark_line: assert property (@(posedge clock) disable iff (rst)
        push && int'(row_reg) < DARK_LINES_PER_END && int'(col_reg) >= DUMMY_LEADING
            |-> push_pixel.region == CCDR_REGION_DARK_LINE)
        else $error("dark line mis-tagged");
    a_dark_tag: assert property (@(posedge clock) disable iff (rst)
        push && int'(col_reg) == DUMMY_LEADING && int'(row_reg) == DARK_LINES_PER_END
            |-> push_pixel.region == CCDR_REGION_DARK)
        else $error("leading dark pixel mis-tagged");
    a_buf_bound: assert property (@(posedge clock) disable iff (rst)
        cnt_reg <= 2'h2)
        else $error("buffer overfilled");
endmodule
`default_nettype wire

// ### ccdr_sensor_model.sv
// Behavioural model of the full-frame sensor as seen through its clock pins
`timescale 1ns/10ps
`default_nettype none
module ccdr_sensor_model
    import ccdr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire ccdr_clocks_t pins,
    output logic [SAMPLE_W-1:0] adc_sample,
    output logic [COL_W-1:0] col_cnt,
    output int viol
);
    logic [ROW_W-1:0] row_cnt = '1;
    logic [ROW_W-1:0] row_seen = '1;
    logic [SAMPLE_W-1:0] code = '0;
    int pkt_cnt = 0;
    int rg_cnt = 0;
    int va = 0;
    int vb = 0;
    int vc = 0;
    assign viol = va + vb + vc;
    assign adc_sample = (pkt_cnt == rg_cnt) ? ~code : code;
    always @(negedge pins.vertical_phase_two or posedge rst)
    begin
        if (rst)
            row_cnt = '1;
        else
        begin
            row_cnt = row_cnt + 1'b1;
            if (pins.horizontal_phase_one !== 1'b1)
                va = va + 1;
        end
    end
    always @(negedge pins.horizontal_phase_one or posedge rst)
    begin
        if (rst)
        begin
            row_seen = '1;
            col_cnt = '0;
            pkt_cnt = 0;
        end
        else
        begin
            if (row_seen != row_cnt)
            begin
                row_seen = row_cnt;
                col_cnt = '0;
            end
            if (pins.vertical_phase_one || pins.vertical_phase_two || pkt_cnt != rg_cnt)
                vb = vb + 1;
            if (col_cnt >= SHIFTS_PER_ROW)
                vb = vb + 1;
            code = (col_cnt < DUMMY_LEADING) ? '0 : {row_cnt[3:0], col_cnt};
            col_cnt = col_cnt + 1'b1;
            pkt_cnt = pkt_cnt + 1;
        end
    end
    always @(posedge pins.reset_gate_clock or posedge rst)
    begin
        if (rst)
            rg_cnt = 0;
        else
            rg_cnt = pkt_cnt;
    end
    always @(posedge clock)
    begin
        if (!rst && (pins.horizontal_phase_two !== ~pins.horizontal_phase_one
            || pins.horizontal_last_gate !== pins.horizontal_phase_one))
            vc = vc + 1;
    end
endmodule
`default_nettype wire

// ### ccd_frame_readout_sequencer_tb.sv
// Self-checking bench for the CCD readout sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module ccd_frame_readout_sequencer_tb
    import ccdr_pkg::*;
;
    localparam int INTEG = 20;
    typedef struct packed {
        logic [COL_W-1:0] col;
        ccdr_region_t region;
        logic scav;
    } ccdr_row_t;
    ccdr_row_t tab [6] = '{'{12'h000, CCDR_REGION_DUMMY, 1'b0}, '{12'h002, CCDR_REGION_DUMMY, 1'b0},
        '{12'h003, CCDR_REGION_DARK_LINE, 1'b1}, '{12'h01a, CCDR_REGION_DARK_LINE, 1'b1},
        '{12'h7d0, CCDR_REGION_DARK_LINE, 1'b0}, '{12'hf99, CCDR_REGION_DARK_LINE, 1'b0}};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic out_ready = 1'b0;
    logic busy;
    logic out_valid;
    logic [SAMPLE_W-1:0] adc_sample;
    logic [COL_W-1:0] sen_col;
    int viol;
    ccdr_clocks_t ccd_clocks;
    ccdr_pixel_t out_pixel;
    int fail_count = 0;
    int comparisons = 0;
    int n;
    logic [COL_W-1:0] exp_col = '0;
    logic [ROW_W-1:0] exp_row = '0;
    always #20 clock = ~clock;
    ccdr_sequencer #(.INTEGRATION_CYCLES(INTEG)) dut (.clock(clock), .rst(rst), .start(start),
        .adc_sample(adc_sample), .busy(busy), .ccd_clocks(ccd_clocks), .out_valid(out_valid),
        .out_ready(out_ready), .out_pixel(out_pixel));
    ccdr_sensor_model sensor (.clock(clock), .rst(rst), .pins(ccd_clocks), .adc_sample(adc_sample),
        .col_cnt(sen_col), .viol(viol));
    task automatic test_done;
    begin
        $display("Mismatches %0d in %0d comparisons", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task automatic step(input int lim);
    begin
        n++;
        if (n > lim)
        begin
            fail_count++;
            $display("CHECK FAILED wait exp done got timeout");
            test_done();
        end
        @(posedge clock);
    end
    endtask
    // ****************
    // Pixel stream monitor
    // ****************
    always @(posedge clock)
    begin
        if (rst)
        begin
            exp_col = '0;
            exp_row = '0;
        end
        else if (out_valid === 1'b1 && out_ready === 1'b1)
        begin
            `CHK("column", exp_col, out_pixel.column)
            `CHK("row", exp_row, out_pixel.row)
            `CHK("sample", (exp_col < DUMMY_LEADING) ? 16'h0000 : {exp_row[3:0], exp_col}, out_pixel.sample)
            foreach (tab[i])
                if (exp_row == 0 && exp_col == tab[i].col)
                begin
                    `CHK("region", tab[i].region, out_pixel.region)
                    `CHK("scavenging", tab[i].scav, out_pixel.scavenging)
                end
            exp_col = exp_col + 1'b1;
            if (exp_col == SHIFTS_PER_ROW)
            begin
                exp_col = '0;
                exp_row = exp_row + 1'b1;
            end
        end
    end
    // ****************
    // Main sequence
    // ****************
    initial
    begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        n = 0;
        while (ccd_clocks.vertical_phase_one !== 1'b1)
        begin
            start <= (n == 5);
            `CHK("phase two idle", 1'b0, ccd_clocks.vertical_phase_two)
            step(200);
        end
        `CHK("integration", 1'b1, n >= INTEG && n <= INTEG + 4)
        `CHK("busy", 1'b1, busy)
        n = 0;
        while (ccd_clocks.vertical_phase_one === 1'b1) step(1000);
        `CHK("phase one width", VPHASE_CYCLES, n)
        n = 0;
        while (ccd_clocks.vertical_phase_two !== 1'b1) step(1000);
        n = 0;
        while (ccd_clocks.vertical_phase_two === 1'b1) step(1000);
        `CHK("phase two width", VPHASE_CYCLES, n)
        repeat (300) @(posedge clock);
        `CHK("stall valid", 1'b1, out_valid)
        `CHK("stall shifts", 12'h003, sen_col)
        `CHK("stall level", 1'b0, ccd_clocks.horizontal_phase_one)
        n = 0;
        while (exp_row != 1 || exp_col < 12'h00a)
        begin
            out_ready <= (n % 7 != 0);
            step(40000);
        end
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK("reset pins", 6'h0a, ccd_clocks)
        `CHK("reset busy", 1'b0, busy)
        `CHK("reset valid", 1'b0, out_valid)
        rst <= 1'b0;
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        out_ready <= 1'b1;
        n = 0;
        while (exp_col < 12'h005) step(2000);
        `CHK("sensor faults", 0, viol)
        test_done();
    end
endmodule
`default_nettype wire
